// File: ssr_pkg.sv
package ssr_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADR_CHIP_STATUS = 8'h00;
    localparam logic [7:0] ADR_FAULT_LATCH = 8'h01;
    localparam logic [7:0] ADR_ALERT_LATCH = 8'h02;
    localparam logic [7:0] ADR_ADDRESS = 8'h03;
    localparam logic [7:0] ADR_IO_CONTROL = 8'h04;
    localparam logic [7:0] ADR_BALANCE = 8'h05;
    localparam logic [7:0] ADR_RESET = 8'h06;

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int ST_LOCKOUT = 0;
    localparam int ST_OVERHEAT = 1;
    localparam int ST_ASLEEP = 2;
    localparam int FL_POWER_UP = 0;
    localparam int FL_CELL_OV = 1;
    localparam int FL_CELL_UV = 2;
    localparam int FL_FORCE = 3;
    localparam int AL_SLEEP = 0;
    localparam int AL_OVERHEAT = 1;
    localparam int AL_OT1 = 2;
    localparam int AL_OT2 = 3;
    localparam int AL_FORCE = 4;
    localparam int IO_AUX = 0;
    localparam int IO_GPIO_OUT = 1;
    localparam int IO_GPIO_IN = 2;
    localparam int IO_TS1 = 3;
    localparam int IO_TS2 = 4;
    localparam int IO_SLEEP = 7;
    localparam int AD_VALID = 7;
    localparam logic [7:0] RESET_CODE = 8'ha5;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [5:0] ADDR_MAX = 6'h3e;
    localparam logic [3:0] FAULT_RESET = 4'h1;
    localparam int CW = 16;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 25;
    localparam int QUAL_US = 50;
    localparam int RST_CMD_US = 300;
    localparam int WARMUP_US = 100;
    localparam int QUAL_CYC_DEF = QUAL_US * CLK_MHZ;
    localparam int RST_CYC_DEF = RST_CMD_US * CLK_MHZ;
    localparam int WARM_CYC_DEF = WARMUP_US * CLK_MHZ;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {SL_ACTIVE, SL_DRAIN, SL_ASLEEP, SL_WAKE} ssr_sleep_e;

    typedef struct packed {
        logic supply_low;
        logic supply_por;
        logic die_hot;
        logic conv_busy;
        logic cell_ov;
        logic cell_uv;
        logic ot1;
        logic ot2;
        logic gpio;
    } ssr_mon_s;

    typedef struct packed {
        logic conv_en;
        logic fault_det_en;
        logic prot_en;
        logic reg5v_en;
        logic aux_en;
        logic comm_en;
        logic [1:0] ts_en;
        logic [5:0] balance;
    } ssr_ctl_s;

endpackage : ssr_pkg

// File: ssr_top.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// [RULE_01] Qualified lockout stops converter, balancing, fault detection
// [RULE_02] Lockout clears balance register, sets lockout status
// [RULE_03] Qualified power-on reset stops everything, communication too
// [RULE_04] Reset release loads defaults, sets power-up flag
// [RULE_05] After reset address flag and address read zero
// [RULE_06] Code a5 to reset register forces short reset
// [RULE_07] Reset command obeyed whatever address is held
// [RULE_08] Overheat kills regulator and converter until cooled; the code keeps them off after cooling until the sleep bit is cleared
// [RULE_09] Overheat sets status, sleep bit, sleep alert
// [RULE_10] Overheat disables secondary protection comparators
// [RULE_11] Pin follows output bit, input bit shows pin
// [RULE_12] Sleep bit set enters sleep, cleared exits
// [RULE_13] Finish running conversion, raise done pin, then sleep
// [RULE_14] Sleep entry sets sleep alert, asserting alert
// [RULE_15] Asleep: only sleep alert, latches kept intact
// [RULE_16] Host clears sleep alert before its own sleep
// [RULE_17] Asleep: regulator, converter, comparators all off
// [RULE_18] Sleep leaves thermistor bias bits untouched
// [RULE_19] Registers stay readable and writable while asleep
// [RULE_20] Wake restores regulator, comparators, converter after warm-up
// [RULE_21] Wake restores latches, outputs assert at once
// [RULE_22] Auxiliary output follows its enable bit
// [RULE_23] Latched flags clear by one, force bits by zero
// [RULE_24] Comparator inputs synchronised and qualified by counter; only supply_low and supply_por pass through the counter
// [RULE_25] Reset command interval counted, registers held, access ignored
module ssr_top
    import ssr_pkg::*;
#(
    parameter int QUAL_CYC = QUAL_CYC_DEF,
    parameter int RST_CYC = RST_CYC_DEF,
    parameter int WARM_CYC = WARM_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire ssr_mon_s mon_i,
    output ssr_ctl_s ctl_o,
    output logic gpio_o,
    output logic gpio_oe_o,
    output logic conv_done_o,
    output logic fault_o,
    output logic alert_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ssr_mon_s sync1;
        ssr_mon_s sync2;
        logic [1:0] qual;
        logic [1:0][CW-1:0] qcnt;
        logic rst_act;
        logic [CW-1:0] rcnt;
        ssr_sleep_e sleep_st;
        logic [CW-1:0] wcnt;
        logic done;
        logic [3:0] fault_lat;
        logic [4:0] alert_lat;
        logic [5:0] addr;
        logic aux;
        logic gpio_out;
        logic [1:0] ts;
        logic sleep;
        logic [5:0] bal;
        logic [7:0] rdata;
        ssr_ctl_s ctl;
        logic fault;
        logic alert;
    } ssr_state_s;

    ssr_state_s st_ff;
    ssr_state_s nxt_st;

    logic [1:0] raw;
    logic comm_ok;
    logic hot;
    logic asleep;
    logic sense_ok;
    logic wr_ok;
    logic addr_ok;

    // ************************************************************
    // Phase decoding
    // ************************************************************
    // The regulator and comparators stay up in every phase but the
    // settled sleep, since a drain still waits on a live conversion.
    function automatic logic powered(input ssr_sleep_e s);
        return s != SL_ASLEEP;
    endfunction : powered

    // The converter may run while awake and while a drain finishes.
    function automatic logic converting(input ssr_sleep_e s);
        return s == SL_ACTIVE || s == SL_DRAIN;
    endfunction : converting

    // Latches reach the pins while awake or warming up; both sleep
    // phases show the sleep alert alone.
    function automatic logic pins_live(input ssr_sleep_e s);
        return s == SL_ACTIVE || s == SL_WAKE;
    endfunction : pins_live

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        // Pins sit outside the clock domain; only sync2 feeds logic.
        nxt_st.sync1 = mon_i; // RULE_24
        nxt_st.sync2 = st_ff.sync1; // RULE_24
        // Read data is cleared in every other cycle, so the bus sees a
        // value only in the cycle right after the strobe.
        nxt_st.rdata = 8'h00;

        // Both supply comparators need the condition to hold, in either
        // direction, for the whole delay before the qualified level moves.
        raw = {st_ff.sync2.supply_por, st_ff.sync2.supply_low};
        for (int i = 0; i < 2; i++) begin
            if (raw[i] == st_ff.qual[i]) begin
                nxt_st.qcnt[i] = '0;
            end else if (st_ff.qcnt[i] == CW'(QUAL_CYC - 1)) begin
                nxt_st.qual[i] = raw[i]; // RULE_24
                nxt_st.qcnt[i] = '0;
            end else begin
                nxt_st.qcnt[i] = st_ff.qcnt[i] + CW'(1);
            end
        end

        // Die heat arrives already filtered by its own hysteresis, so it
        // is used straight from the synchroniser with no extra delay.
        hot = st_ff.sync2.die_hot;
        comm_ok = !st_ff.qual[1] && !st_ff.rst_act; // RULE_03
        asleep = st_ff.sleep_st != SL_ACTIVE;
        sense_ok = !asleep && !st_ff.qual[0] && !hot;
        wr_ok = comm_ok && wr_i;
        addr_ok = st_ff.addr >= ADDR_MIN && st_ff.addr <= ADDR_MAX;

        // ********************************************************
        // Register reads
        // ********************************************************
        if (comm_ok && rd_i) begin // RULE_19
            unique case (addr_i)
                ADR_CHIP_STATUS: begin
                    nxt_st.rdata[ST_LOCKOUT] = st_ff.qual[0]; // RULE_02
                    nxt_st.rdata[ST_OVERHEAT] = hot; // RULE_09
                    nxt_st.rdata[ST_ASLEEP] = asleep;
                end
                ADR_FAULT_LATCH: nxt_st.rdata = {4'h0, st_ff.fault_lat};
                ADR_ALERT_LATCH: nxt_st.rdata = {3'h0, st_ff.alert_lat};
                ADR_ADDRESS: begin
                    nxt_st.rdata[5:0] = st_ff.addr;
                    nxt_st.rdata[AD_VALID] = addr_ok; // RULE_05
                end
                ADR_IO_CONTROL: begin
                    nxt_st.rdata[IO_AUX] = st_ff.aux;
                    nxt_st.rdata[IO_GPIO_OUT] = st_ff.gpio_out;
                    nxt_st.rdata[IO_GPIO_IN] = st_ff.sync2.gpio; // RULE_11
                    nxt_st.rdata[IO_TS2:IO_TS1] = st_ff.ts;
                    nxt_st.rdata[IO_SLEEP] = st_ff.sleep;
                end
                ADR_BALANCE: nxt_st.rdata = {2'h0, st_ff.bal};
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // ********************************************************
        // Register writes
        // ********************************************************
        // Writes in a reset hold are dropped here, and the hold below
        // reloads defaults anyway, so nothing written then survives.
        if (wr_ok) begin // RULE_19
            unique case (addr_i)
                ADR_FAULT_LATCH: begin
                    nxt_st.fault_lat[2:0] = st_ff.fault_lat[2:0]
                        & ~wdata_i[2:0]; // RULE_23
                    nxt_st.fault_lat[FL_FORCE] = wdata_i[FL_FORCE]; // RULE_23
                end
                ADR_ALERT_LATCH: begin
                    nxt_st.alert_lat[3:0] = st_ff.alert_lat[3:0]
                        & ~wdata_i[3:0]; // RULE_23
                    nxt_st.alert_lat[AL_FORCE] = wdata_i[AL_FORCE]; // RULE_23
                end
                ADR_ADDRESS: nxt_st.addr = wdata_i[5:0];
                ADR_IO_CONTROL: begin
                    nxt_st.aux = wdata_i[IO_AUX];
                    nxt_st.gpio_out = wdata_i[IO_GPIO_OUT];
                    nxt_st.ts = wdata_i[IO_TS2:IO_TS1];
                    nxt_st.sleep = wdata_i[IO_SLEEP]; // RULE_12
                end
                ADR_BALANCE: nxt_st.bal = wdata_i[5:0];
                ADR_RESET: begin
                    // The command path carries no device address here, so
                    // a broadcast reset lands even with no valid address.
                    if (wdata_i == RESET_CODE) begin // RULE_07
                        nxt_st.rst_act = 1'b1; // RULE_06
                        nxt_st.rcnt = '0;
                    end
                end
                default: begin
                end
            endcase
        end

        // ********************************************************
        // Event latches; a set in the clearing cycle wins
        // ********************************************************
        if (sense_ok) begin // RULE_15
            if (st_ff.sync2.cell_ov) begin
                nxt_st.fault_lat[FL_CELL_OV] = 1'b1;
            end
            if (st_ff.sync2.cell_uv) begin
                nxt_st.fault_lat[FL_CELL_UV] = 1'b1;
            end
            if (st_ff.sync2.ot1) begin
                nxt_st.alert_lat[AL_OT1] = 1'b1;
            end
            if (st_ff.sync2.ot2) begin
                nxt_st.alert_lat[AL_OT2] = 1'b1;
            end
        end

        // Overheat also drives the part to sleep, so the host sees the
        // same sleep alert whichever way the regulator went down.
        if (hot) begin
            nxt_st.sleep = 1'b1; // RULE_09
            nxt_st.alert_lat[AL_SLEEP] = 1'b1; // RULE_09
            if (!asleep) begin
                nxt_st.alert_lat[AL_OVERHEAT] = 1'b1;
            end
        end

        // Lockout forces the balance register to zero for as long as it
        // holds, so a write cannot re-arm balancing under low supply.
        if (nxt_st.qual[0]) begin
            nxt_st.bal = '0; // RULE_02
        end

        // ********************************************************
        // Sleep sequencing
        // ********************************************************
        // Draining keeps the converter powered so a running conversion
        // ends cleanly; the done pin then tells the host that the last
        // result is safe to fetch, rising in the same cycle the analog side goes dark.
        unique case (st_ff.sleep_st)
            SL_ACTIVE: begin
                nxt_st.done = 1'b0;
                if (nxt_st.sleep) begin
                    nxt_st.sleep_st = SL_DRAIN; // RULE_12
                end
            end

            SL_DRAIN: begin
                if (!nxt_st.sleep) begin
                    nxt_st.sleep_st = SL_ACTIVE;
                end else if (!st_ff.sync2.conv_busy) begin
                    nxt_st.done = 1'b1; // RULE_13
                    nxt_st.alert_lat[AL_SLEEP] = 1'b1; // RULE_14
                    nxt_st.sleep_st = SL_ASLEEP;
                end
            end

            SL_ASLEEP: begin
                if (!nxt_st.sleep) begin
                    nxt_st.sleep_st = SL_WAKE; // RULE_12
                    nxt_st.wcnt = '0;
                    nxt_st.done = 1'b0;
                end
            end

            // Warm-up counts from the wake write; the converter stays
            // off until it ends, while a cold start enters active at once.
            SL_WAKE: begin
                nxt_st.done = 1'b0;
                if (nxt_st.sleep) begin
                    nxt_st.sleep_st = SL_DRAIN;
                end else if (st_ff.wcnt == CW'(WARM_CYC - 1)) begin
                    nxt_st.sleep_st = SL_ACTIVE; // RULE_20
                end else begin
                    nxt_st.wcnt = st_ff.wcnt + CW'(1);
                end
            end
        endcase

        // ********************************************************
        // Reset hold
        // ********************************************************
        if (st_ff.rst_act) begin
            if (st_ff.rcnt == CW'(RST_CYC - 1)) begin
                nxt_st.rst_act = 1'b0; // RULE_25
            end else begin
                nxt_st.rcnt = st_ff.rcnt + CW'(1); // RULE_25
            end
        end

        // A command reset and a supply reset share this hold; they
        // differ only in how long it lasts.
        if (nxt_st.qual[1] || st_ff.rst_act) begin
            // Defaults are reloaded every held cycle, so release comes
            // with defaults and the power-up flag already standing.
            nxt_st.fault_lat = FAULT_RESET; // RULE_04
            nxt_st.alert_lat = '0;
            nxt_st.addr = '0; // RULE_05
            nxt_st.aux = 1'b0;
            nxt_st.gpio_out = 1'b0;
            nxt_st.ts = '0;
            nxt_st.sleep = 1'b0;
            nxt_st.bal = '0;
            nxt_st.sleep_st = SL_ACTIVE;
            nxt_st.done = 1'b0;
            nxt_st.wcnt = '0;
        end

        // ********************************************************
        // Registered outputs
        // ********************************************************
        nxt_st.ctl.comm_en = !nxt_st.qual[1] && !nxt_st.rst_act; // RULE_03

        nxt_st.ctl.reg5v_en = nxt_st.ctl.comm_en && !hot // RULE_08
            && powered(nxt_st.sleep_st); // RULE_17
        nxt_st.ctl.conv_en = nxt_st.ctl.reg5v_en && !nxt_st.qual[0] // RULE_01
            && converting(nxt_st.sleep_st); // RULE_13 RULE_20
        nxt_st.ctl.prot_en = nxt_st.ctl.reg5v_en; // RULE_10
        nxt_st.ctl.fault_det_en = nxt_st.ctl.prot_en
            && !nxt_st.qual[0]; // RULE_01

        nxt_st.ctl.aux_en = nxt_st.ctl.reg5v_en && nxt_st.aux; // RULE_22
        nxt_st.ctl.ts_en = nxt_st.ts; // RULE_18
        nxt_st.ctl.balance = nxt_st.ctl.fault_det_en ? nxt_st.bal : '0;

        // Latch contents survive sleep; only the pins are gated, so the
        // old condition shows again the moment sleep is left.
        if (pins_live(nxt_st.sleep_st)) begin
            nxt_st.fault = |nxt_st.fault_lat; // RULE_21
            nxt_st.alert = |nxt_st.alert_lat; // RULE_21
        end else begin
            nxt_st.fault = 1'b0; // RULE_15
            nxt_st.alert = nxt_st.alert_lat[AL_SLEEP]; // RULE_14
        end
        if (!nxt_st.ctl.comm_en) begin
            nxt_st.fault = 1'b0;
            nxt_st.alert = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Holding ce_i low freezes the synchronisers as well, so a stalled
    // part never acts on an input taken halfway.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
            st_ff.fault_lat <= FAULT_RESET; // RULE_04
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign ctl_o = st_ff.ctl;
    // Open-drain style: a one releases the pin so it can be read.
    assign gpio_o = 1'b0;
    assign gpio_oe_o = !st_ff.gpio_out; // RULE_11
    assign conv_done_o = st_ff.done;
    assign fault_o = st_ff.fault;
    assign alert_o = st_ff.alert;

endmodule : ssr_top

// File: ssr_top_properties.sv
`timescale 1ns/10ps
// ************************************************************
// Port-level checks of the supply, reset and sleep controller
// ************************************************************
module ssr_top_properties
    import ssr_pkg::*;
#(
    parameter int QUAL_CYC = 4,
    parameter int RST_CYC = 10,
    parameter int WARM_CYC = 6
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire ssr_mon_s mon_i,
    input wire ssr_ctl_s ctl_o,
    input wire logic gpio_o,
    input wire logic gpio_oe_o,
    input wire logic conv_done_o,
    input wire logic fault_o,
    input wire logic alert_o
);
    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    chk_refused_read: assert property (
        $past(resetn_i) && rd_i && !ctl_o.comm_en |=> rdata_o == 8'h00)
        else $error("read answered while the bus is closed");
    chk_pin_follows: assert property (
        wr_i && addr_i == ADR_IO_CONTROL && ctl_o.comm_en |-> ##2
        (gpio_oe_o == !$past(wdata_i[IO_GPIO_OUT], 2) && !gpio_o))
        else $error("pin drive does not follow the output bit");
    chk_aux_supply: assert property (
        wr_i && addr_i == ADR_IO_CONTROL && ctl_o.comm_en |=>
        ctl_o.aux_en == ($past(wdata_i[IO_AUX]) && ctl_o.reg5v_en))
        else $error("auxiliary output does not follow its enable bit");
    chk_asleep_off: assert property (
        conv_done_o |-> !ctl_o.reg5v_en && !ctl_o.conv_en && !ctl_o.prot_en)
        else $error("supplies or comparators left on while asleep");
    chk_sleep_alert: assert property (
        $rose(conv_done_o) |-> ##[0:1] alert_o)
        else $error("sleep entry without alert");
    chk_reset_hold: assert property (
        $fell(ctl_o.comm_en) && !mon_i.supply_por |->
        (!ctl_o.comm_en)[*8] ##[1:5] ctl_o.comm_en)
        else $error("reset command interval has the wrong length");
    chk_lockout_cut: assert property (
        mon_i.supply_low[*8] |-> ##2
        (ctl_o.balance == 6'h00 && !ctl_o.conv_en && ctl_o.comm_en))
        else $error("lockout left converter or balancing running");
    chk_overheat_cut: assert property (
        mon_i.die_hot[*4] |-> ##1
        (!ctl_o.reg5v_en && !ctl_o.conv_en && !ctl_o.prot_en))
        else $error("overheat left regulator or protection on");
endmodule : ssr_top_properties

bind ssr_top ssr_top_properties #(
    .QUAL_CYC(QUAL_CYC),
    .RST_CYC(RST_CYC),
    .WARM_CYC(WARM_CYC)
) u_props (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .mon_i(mon_i),
    .ctl_o(ctl_o),
    .gpio_o(gpio_o),
    .gpio_oe_o(gpio_oe_o),
    .conv_done_o(conv_done_o),
    .fault_o(fault_o),
    .alert_o(alert_o)
);

// File: ssr_host.sv
`timescale 1ns/10ps
// ************************************************************
// Host controller model on the register port
// ************************************************************
module ssr_host
    import ssr_pkg::*;
(
    input wire logic clk_sys_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released lines are scrambled so nothing relies on stale values.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd

    task automatic clear_sleep_alert;
        wr(ADR_ALERT_LATCH, 8'h01);
        wr(ADR_ALERT_LATCH, 8'h00);
    endtask : clear_sleep_alert
endmodule : ssr_host

// File: supply_reset_sleep_control_test.sv
`timescale 1ns/10ps
module supply_reset_sleep_control_test;
    import ssr_pkg::*;
    localparam int QC = 4;
    localparam int RC = 10;
    localparam int WC = 6;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic w;
        logic [7:0] e;
    } ssr_row_s;
    logic clk_sys_i;
    logic resetn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] got;
    logic wr;
    logic rd;
    logic gpio;
    logic gpio_oe;
    logic pin;
    logic conv_done;
    logic fault;
    logic alert;
    ssr_mon_s mon;
    ssr_mon_s mon_in;
    ssr_ctl_s ctl;
    int errors;
    int samples_checked;
    ssr_row_s rows [10] = '{
        '{8'h00, 8'h00, 1'b0, 8'h00}, '{8'h01, 8'h00, 1'b0, 8'h01},
        '{8'h03, 8'h00, 1'b0, 8'h00}, '{8'h05, 8'h00, 1'b0, 8'h00},
        '{8'h03, 8'h05, 1'b1, 8'h85}, '{8'h03, 8'h3f, 1'b1, 8'h3f},
        '{8'h07, 8'hff, 1'b1, 8'h00}, '{8'h04, 8'h1a, 1'b1, 8'h1e},
        '{8'h04, 8'h19, 1'b1, 8'h19}, '{8'h04, 8'h1a, 1'b1, 8'h1e}};

    // The pin is open drain with a pull-up, so a released pin reads high.
    assign pin = gpio_oe ? gpio : 1'b1;
    assign mon_in = {mon[8:1], pin};

    ssr_top #(.QUAL_CYC(QC), .RST_CYC(RC), .WARM_CYC(WC)) u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .mon_i(mon_in), .ctl_o(ctl), .gpio_o(gpio),
        .gpio_oe_o(gpio_oe), .conv_done_o(conv_done), .fault_o(fault),
        .alert_o(alert));
    ssr_host u_host (.clk_sys_i(clk_sys_i), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

    task automatic chk(input string n, input logic [7:0] e,
            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cb(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask : cb

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, got);
        chk($sformatf("reg %h", a), e, got);
    endtask : rc

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic conclude;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        conclude();
    end

    initial begin
        resetn = 1'b0;
        mon = '0;
        errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_sys_i);
        resetn <= 1'b1;
        cyc(2);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                u_host.wr(rows[i].a, rows[i].d);
            end
            cyc(4);
            rc(rows[i].a, rows[i].e);
            if (rows[i].a == ADR_IO_CONTROL) begin
                cb("aux", rows[i].d[IO_AUX], ctl.aux_en);
            end
        end
        // ************************************************************
        // Sleep with a conversion running and a forced fault
        // ************************************************************
        u_host.wr(ADR_FAULT_LATCH, 8'h08);
        mon.conv_busy <= 1'b1;
        u_host.wr(ADR_IO_CONTROL, 8'h9a);
        cyc(6);
        cb("done early", 1'b0, conv_done);
        cb("drain conv", 1'b1, ctl.conv_en);
        mon.conv_busy <= 1'b0;
        cyc(6);
        cb("done", 1'b1, conv_done);
        cb("alert", 1'b1, alert);
        cb("fault gated", 1'b0, fault);
        cb("reg5v", 1'b0, ctl.reg5v_en);
        chk("ts", 8'h03, {6'h00, ctl.ts_en});
        rc(ADR_FAULT_LATCH, 8'h09);
        u_host.clear_sleep_alert();
        cyc(3);
        cb("alert off", 1'b0, alert);
        u_host.wr(ADR_IO_CONTROL, 8'h1a);
        cyc(3);
        cb("fault back", 1'b1, fault);
        cb("warming", 1'b0, ctl.conv_en);
        cyc(WC + 4);
        cb("conv back", 1'b1, ctl.conv_en);
        cb("reg5v back", 1'b1, ctl.reg5v_en);
        u_host.wr(ADR_FAULT_LATCH, 8'h01);
        rc(ADR_FAULT_LATCH, 8'h00);
        // ************************************************************
        // Lockout, overheat, reset command and power-on reset
        // ************************************************************
        u_host.wr(ADR_BALANCE, 8'h3f);
        mon.supply_low <= 1'b1;
        cyc(QC + 6);
        cb("fault det", 1'b0, ctl.fault_det_en);
        rc(ADR_BALANCE, 8'h00);
        rc(ADR_CHIP_STATUS, 8'h01);
        mon.supply_low <= 1'b0;
        cyc(QC + 6);
        rc(ADR_CHIP_STATUS, 8'h00);
        mon.die_hot <= 1'b1;
        cyc(8);
        rc(ADR_CHIP_STATUS, 8'h06);
        rc(ADR_IO_CONTROL, 8'h9e);
        rc(ADR_ALERT_LATCH, 8'h03);
        mon.die_hot <= 1'b0;
        cyc(4);
        u_host.wr(ADR_IO_CONTROL, 8'h1a);
        u_host.wr(ADR_ALERT_LATCH, 8'h03);
        cyc(WC + 6);
        cb("reg5v cool", 1'b1, ctl.reg5v_en);
        u_host.wr(ADR_ADDRESS, 8'h05);
        u_host.wr(ADR_RESET, 8'h5a);
        rc(ADR_ADDRESS, 8'h85);
        u_host.wr(ADR_RESET, RESET_CODE);
        cyc(1);
        u_host.wr(ADR_BALANCE, 8'h3f);
        rc(ADR_ADDRESS, 8'h00);
        cyc(RC + 4);
        rc(ADR_FAULT_LATCH, 8'h01);
        rc(ADR_BALANCE, 8'h00);
        u_host.wr(ADR_FAULT_LATCH, 8'h01);
        mon.supply_por <= 1'b1;
        cyc(QC + 6);
        cb("comm", 1'b0, ctl.comm_en);
        rc(ADR_IO_CONTROL, 8'h00);
        mon.supply_por <= 1'b0;
        cyc(QC + 6);
        rc(ADR_FAULT_LATCH, 8'h01);
        rc(ADR_ADDRESS, 8'h00);
        conclude();
    end
endmodule : supply_reset_sleep_control_test
